// ===== verilog/i2c_host_timing_irq.sv
`timescale 1ns/1ps
module i2c_host_timing_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [i2c_tim_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // SCL pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Byte engine status, same clock
  input wire logic run_req,
  input wire logic fast_mode,
  input wire logic byte_rx_done,
  input wire logic byte_tx_done,
  input wire logic nack_arb_lost,
  input wire logic start_unknown,
  input wire logic ev_length_error,
  input wire logic ev_client_stretch_timeout,
  input wire logic ev_host_stretch_timeout,
  input wire logic ev_scl_low_timeout,
  input wire logic ev_arbitration_lost,
  input wire logic ev_bus_error,
  input wire logic rx_nack,
  input wire logic [1:0] bus_state,
  input wire logic [7:0] rx_data,
  // Requests to the byte engine
  output logic resume_go,
  output logic ack_go,
  output logic ack_nack,
  output logic cmd_go,
  output logic [1:0] cmd_code,
  output logic addr_go,
  output logic [7:0] addr_value,
  output logic data_go,
  output logic [7:0] data_value
);
  import i2c_tim_pkg::*;

  typedef struct packed {
    scl_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [31:0] timing;
    logic [7:0] en;
    logic [7:0] flags;
    logic [15:0] status;
    logic smart;
    logic ack_act;
    logic hold;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    logic scl_oe;
    logic resume;
    logic ack_go;
    logic ack_nack;
    logic cmd_go;
    logic [1:0] cmd;
    logic addr_go;
    logic [7:0] addr;
    logic data_go;
    logic [7:0] data;
  } state_t;

  state_t s_ff;
  state_t nxt_s;
  logic scl_sync;
  logic wr_acc;
  logic rd_acc;
  logic [IDX_W-1:0] idx;
  logic [15:0] st_set;
  logic client_set;
  logic host_set;
  logic arb_now;
  logic cmd_valid;
  logic rel;
  logic [7:0] fast_low;
  logic [7:0] fast_high;
  logic [7:0] std_low;
  logic [7:0] std_high;
  logic [CNT_W-1:0] low_len;
  logic [CNT_W-1:0] high_len;

  pin_sync u_scl_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(scl_in),
    .level(scl_sync)
  );

  // ==========================================
  // Decode and events
  // A request is taken only in the single cycle that waitrequest is low
  assign wr_acc = avs_write & ~s_ff.waitreq;
  assign rd_acc = avs_read & ~s_ff.waitreq;
  assign idx = avs_address[ADDR_W-1:2];

  always_comb begin
    st_set = RST_STATUS;
    st_set[ST_LENGTH_ERROR] = ev_length_error;
    st_set[ST_CLIENTTO] = ev_client_stretch_timeout;
    st_set[ST_HOSTTO] = ev_host_stretch_timeout;
    st_set[ST_LOWTO] = ev_scl_low_timeout;
    st_set[ST_ARB] = ev_arbitration_lost;
    st_set[ST_BUS_ERROR_FLAG] = ev_bus_error;
  end

  assign client_set = byte_rx_done & ~ev_arbitration_lost & ~ev_bus_error;
  assign host_set = byte_tx_done | nack_arb_lost | start_unknown;
  assign arb_now = s_ff.status[ST_ARB] | ev_arbitration_lost;
  // Commands only count while one of the on-bus flags is up
  assign cmd_valid = wr_acc && idx == IDX_CONTROL_B && avs_byteenable[2]
    && avs_writedata[CB_CMD+:2] != CMD_NONE
    && (s_ff.flags[FLAG_CLIENT] | s_ff.flags[FLAG_HOST]);
  assign rel = (wr_acc && idx == IDX_ADDR && avs_byteenable[0])
    | (wr_acc && idx == IDX_DATA && avs_byteenable[0])
    | (rd_acc && idx == IDX_DATA && s_ff.smart)
    | cmd_valid;

  // ==========================================
  // Phase lengths, counted down to zero so a value N lasts N plus one cycles
  assign fast_low = s_ff.timing[FAST_LOW_LSB+:BYTE_W];
  assign fast_high = s_ff.timing[FAST_HIGH_LSB+:BYTE_W];
  assign std_low = s_ff.timing[STD_LOW_LSB+:BYTE_W];
  assign std_high = s_ff.timing[STD_HIGH_LSB+:BYTE_W];
  assign low_len = fast_mode ? ((fast_low != 8'h00) ? fast_low : fast_high)
    : ((std_low != 8'h00) ? std_low : std_high);
  assign high_len = fast_mode ? fast_high : std_high;

  always_comb begin
    logic [31:0] rd;
    logic [7:0] flag_clr;
    logic [7:0] flag_set;
    logic [15:0] st_clr;
    rd = 32'h0000_0000;
    flag_clr = 8'h00;
    flag_set = 8'h00;
    st_clr = 16'h0000;
    nxt_s = s_ff;
    nxt_s.resume = 1'b0;
    nxt_s.ack_go = 1'b0;
    nxt_s.cmd_go = 1'b0;
    nxt_s.addr_go = 1'b0;
    nxt_s.data_go = 1'b0;

    // ==========================================
    // Bus handshake: one wait cycle, then a one-cycle answer
    nxt_s.waitreq = ~((avs_read | avs_write) & s_ff.waitreq);
    if (avs_read && s_ff.waitreq) begin
      case (idx)
        IDX_CONTROL_B: begin
          rd[CB_SMART] = s_ff.smart;
          rd[CB_ACKACT] = s_ff.ack_act;
        end
        IDX_SCL_TIMING: rd = s_ff.timing;
        IDX_IRQ_EN_CLR, IDX_IRQ_EN_SET: rd[7:0] = s_ff.en;
        IDX_IRQ_FLAGS: rd[7:0] = s_ff.flags & FLAG_MASK;
        IDX_BUS_STATUS: begin
          rd[15:0] = s_ff.status & ST_STICKY;
          rd[ST_CLKHOLD] = s_ff.hold;
          rd[ST_BUSSTATE+:2] = bus_state;
          rd[ST_RXNACK] = rx_nack;
        end
        IDX_DATA: rd[7:0] = rx_data;
        IDX_ADDR: rd[7:0] = s_ff.addr;
        default: rd = 32'h0000_0000;
      endcase
      nxt_s.rdata = rd;
    end

    // ==========================================
    // Register writes, byte lanes honoured
    if (wr_acc) begin
      case (idx)
        IDX_CONTROL_B: begin
          if (avs_byteenable[1]) begin
            nxt_s.smart = avs_writedata[CB_SMART];
          end
          if (avs_byteenable[2]) begin
            nxt_s.ack_act = avs_writedata[CB_ACKACT];
          end
        end
        IDX_SCL_TIMING: begin
          for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
              nxt_s.timing[i*BYTE_W+:BYTE_W] = avs_writedata[i*BYTE_W+:BYTE_W];
            end
          end
        end
        IDX_IRQ_EN_CLR: begin
          if (avs_byteenable[0]) begin
            nxt_s.en = s_ff.en & ~(avs_writedata[7:0] & FLAG_MASK);
          end
        end
        IDX_IRQ_EN_SET: begin
          if (avs_byteenable[0]) begin
            nxt_s.en = s_ff.en | (avs_writedata[7:0] & FLAG_MASK);
          end
        end
        IDX_IRQ_FLAGS: begin
          if (avs_byteenable[0]) begin
            flag_clr = avs_writedata[7:0] & FLAG_MASK;
          end
        end
        IDX_BUS_STATUS: begin
          if (avs_byteenable[0]) begin
            st_clr[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            st_clr[15:8] = avs_writedata[15:8];
          end
        end
        IDX_DATA: begin
          if (avs_byteenable[0]) begin
            nxt_s.data = avs_writedata[7:0];
            nxt_s.data_go = 1'b1;
          end
        end
        IDX_ADDR: begin
          if (avs_byteenable[0]) begin
            nxt_s.addr = avs_writedata[7:0];
            nxt_s.addr_go = 1'b1;
            // A new address starts a fresh transfer, old errors go
            st_clr = ST_STICKY;
          end
        end
        default: begin
        end
      endcase
    end

    // ==========================================
    // Commands and acknowledge action
    if (cmd_valid) begin
      nxt_s.cmd_go = 1'b1;
      nxt_s.cmd = avs_writedata[CB_CMD+:2];
      nxt_s.ack_go = 1'b1;
      nxt_s.ack_nack = avs_writedata[CB_ACKACT];
    end
    if (rd_acc && idx == IDX_DATA && s_ff.smart) begin
      nxt_s.ack_go = 1'b1;
      nxt_s.ack_nack = s_ff.ack_act;
    end

    // ==========================================
    // Flags: hardware set wins over any clear in the same cycle
    flag_set[FLAG_ERROR] = |st_set;
    flag_set[FLAG_CLIENT] = client_set;
    flag_set[FLAG_HOST] = host_set;
    if (rel) begin
      flag_clr[FLAG_CLIENT] = 1'b1;
      flag_clr[FLAG_HOST] = 1'b1;
    end
    nxt_s.flags = ((s_ff.flags & ~flag_clr) | flag_set) & FLAG_MASK;
    nxt_s.status = ((s_ff.status & ~st_clr) | st_set) & ST_STICKY;
    // Writing a flag clear never touches the stretch, only a release does
    nxt_s.hold = (s_ff.hold & ~rel) | client_set | (host_set & ~arb_now);
    nxt_s.resume = rel & s_ff.hold;
    nxt_s.irq = |(nxt_s.flags & nxt_s.en);

    // ==========================================
    // SCL phase engine
    case (s_ff.st)
      SCL_IDLE: begin
        nxt_s.scl_oe = 1'b0;
        if (run_req) begin
          nxt_s.st = SCL_LOW;
          nxt_s.cnt = low_len;
          nxt_s.scl_oe = 1'b1;
        end
      end
      SCL_LOW: begin
        nxt_s.scl_oe = 1'b1;
        if (s_ff.cnt != 8'h00) begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end else if (!s_ff.hold) begin
          nxt_s.st = SCL_HIGH;
          nxt_s.cnt = high_len;
          nxt_s.scl_oe = 1'b0;
        end
      end
      SCL_HIGH: begin
        nxt_s.scl_oe = 1'b0;
        if (s_ff.cnt != 8'h00) begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end else if (!scl_sync) begin
          // A client stretching SCL extends the high phase
          nxt_s.cnt = s_ff.cnt;
        end else if (run_req) begin
          nxt_s.st = SCL_LOW;
          nxt_s.cnt = low_len;
          nxt_s.scl_oe = 1'b1;
        end else begin
          nxt_s.st = SCL_FREE;
          nxt_s.cnt = std_high;
        end
      end
      SCL_FREE: begin
        nxt_s.scl_oe = 1'b0;
        if (s_ff.cnt != 8'h00) begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end else begin
          nxt_s.st = SCL_IDLE;
        end
      end
      default: begin
        nxt_s.st = SCL_IDLE;
        nxt_s.scl_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '{st: SCL_IDLE, cnt: 8'h00, timing: RST_TIMING, en: RST_EN,
        flags: RST_FLAGS, status: RST_STATUS, waitreq: 1'b1, rdata: 32'h0000_0000,
        default: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata = s_ff.rdata;
  assign avs_waitrequest = s_ff.waitreq;
  assign irq = s_ff.irq;
  assign scl_out = 1'b0;
  assign scl_oe = s_ff.scl_oe;
  assign resume_go = s_ff.resume;
  assign ack_go = s_ff.ack_go;
  assign ack_nack = s_ff.ack_nack;
  assign cmd_go = s_ff.cmd_go;
  assign cmd_code = s_ff.cmd;
  assign addr_go = s_ff.addr_go;
  assign addr_value = s_ff.addr;
  assign data_go = s_ff.data_go;
  assign data_value = s_ff.data;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [8:0] low_run_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_run_ff <= 9'h000;
    end else if (s_ff.st == SCL_LOW) begin
      low_run_ff <= low_run_ff + 9'h001;
    end else begin
      low_run_ff <= 9'h000;
    end
  end

  low_phase_a:
  assert property ((s_ff.st == SCL_LOW && nxt_s.st == SCL_HIGH && !$past(s_ff.hold)
    && $stable(s_ff.timing) && $stable(fast_mode))
    |-> low_run_ff == {1'b0, low_len})
    else $error("SCL low phase length wrong");
  high_load_a:
  assert property ((s_ff.st == SCL_LOW && nxt_s.st == SCL_HIGH)
    |=> s_ff.cnt == $past(high_len) && !scl_oe)
    else $error("SCL high phase load wrong");
  en_clear_a:
  assert property ((wr_acc && idx == IDX_IRQ_EN_CLR && avs_byteenable[0])
    |=> (s_ff.en & $past(avs_writedata[7:0] & FLAG_MASK)) == 8'h00
    && (s_ff.en | $past(avs_writedata[7:0])) == ($past(s_ff.en) | $past(avs_writedata[7:0])))
    else $error("Enable clear misbehaves");
  en_set_a:
  assert property ((wr_acc && idx == IDX_IRQ_EN_SET && avs_byteenable[0])
    |=> s_ff.en == ($past(s_ff.en) | $past(avs_writedata[7:0] & FLAG_MASK)))
    else $error("Enable set misbehaves");
  en_shared_a:
  assert property ((rd_acc && (idx == IDX_IRQ_EN_CLR || idx == IDX_IRQ_EN_SET))
    |-> avs_readdata[7:0] == s_ff.en)
    else $error("Enable views differ");
  err_flag_a:
  assert property ((|st_set) |=> s_ff.flags[FLAG_ERROR] && (irq || !s_ff.en[FLAG_ERROR]))
    else $error("Error flag not set");
  client_flag_a:
  assert property (client_set |=> s_ff.flags[FLAG_CLIENT] && s_ff.hold)
    else $error("Client flag or stretch missing");
  release_a:
  assert property ($fell(s_ff.hold) |-> $past(rel) ##0 resume_go)
    else $error("Stretch ended without release");
  wipe_keeps_a:
  assert property ((s_ff.hold && !rel && wr_acc && idx == IDX_IRQ_FLAGS
    && avs_byteenable[0] && avs_writedata[FLAG_CLIENT] && !client_set)
    |=> s_ff.hold && !s_ff.flags[FLAG_CLIENT])
    else $error("Flag clear ended stretch");
  host_flag_a:
  assert property (host_set |=> s_ff.flags[FLAG_HOST])
    else $error("Host flag not set");
  no_stretch_a:
  assert property ((host_set && arb_now && !client_set && !s_ff.hold) |=> !s_ff.hold)
    else $error("Stretch after arbitration loss");
  smart_ack_a:
  assert property ((rd_acc && idx == IDX_DATA && s_ff.smart)
    |=> ack_go && ack_nack == $past(s_ff.ack_act))
    else $error("Smart read gave no acknowledge");
  irq_level_a:
  assert property (irq == |(s_ff.flags & s_ff.en))
    else $error("Interrupt level wrong");
  reserved_zero_a:
  assert property ((rd_acc && idx == IDX_IRQ_FLAGS) |-> (avs_readdata[7:0] & ~FLAG_MASK) == 8'h00)
    else $error("Reserved flag bits not zero");
endmodule

// ===== verilog/i2c_tim_pkg.sv
package i2c_tim_pkg;
  // ==========================================
  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 8;
  // ==========================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONTROL_B = 8'h04;
  localparam logic [IDX_W-1:0] IDX_SCL_TIMING = 8'h0C;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN_CLR = 8'h14;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN_SET = 8'h16;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 8'h18;
  localparam logic [IDX_W-1:0] IDX_BUS_STATUS = 8'h1A;
  localparam logic [IDX_W-1:0] IDX_DATA = 8'h20;
  localparam logic [IDX_W-1:0] IDX_ADDR = 8'h24;
  // ==========================================
  // Timing fields
  localparam int FAST_LOW_LSB = 24;
  localparam int FAST_HIGH_LSB = 16;
  localparam int STD_LOW_LSB = 8;
  localparam int STD_HIGH_LSB = 0;
  localparam logic [31:0] RST_TIMING = 32'h0000_0000;
  // ==========================================
  // Flag and enable layout
  localparam int FLAG_HOST = 0;
  localparam int FLAG_CLIENT = 1;
  localparam int FLAG_ERROR = 7;
  localparam logic [7:0] FLAG_MASK = 8'h83;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_EN = 8'h00;
  // ==========================================
  // Status layout
  localparam int ST_BUS_ERROR_FLAG = 0;
  localparam int ST_ARB = 1;
  localparam int ST_RXNACK = 2;
  localparam int ST_BUSSTATE = 4;
  localparam int ST_LOWTO = 6;
  localparam int ST_CLKHOLD = 7;
  localparam int ST_HOSTTO = 8;
  localparam int ST_CLIENTTO = 9;
  localparam int ST_LENGTH_ERROR = 10;
  localparam logic [15:0] ST_STICKY = 16'h0743;
  localparam logic [15:0] RST_STATUS = 16'h0000;
  // ==========================================
  // Control B layout
  localparam int CB_SMART = 8;
  localparam int CB_CMD = 16;
  localparam int CB_ACKACT = 18;
  localparam logic [1:0] CMD_NONE = 2'h0;
  typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_HIGH, SCL_FREE} scl_state_t;
endpackage

// ===== verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin level
  input wire logic pin,
  output logic level
);
  logic meta_ff;

  // Idle I2C lines float high, so both stages reset high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b1;
      level <= 1'b1;
    end else begin
      meta_ff <= pin;
      level <= meta_ff;
    end
  end
endmodule

// ===== verif/scl_client_model.sv
`timescale 1ns/1ps
module scl_client_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wire as driven by the host
  input wire logic scl_oe,
  input wire logic scl_out,
  // Stretch length asked by the bench, in cycles
  input wire logic [7:0] stretch_cyc,
  // Resolved wire level
  output logic scl_line
);
  typedef struct packed {
    logic oe_q;
    logic [7:0] hold_cnt;
  } client_st_t;
  client_st_t st_ff;
  client_st_t nxt_st;
  logic rel_now;
  // ==========================================
  // Slow client: holds SCL low for a while after the host lets go
  assign rel_now = st_ff.oe_q && !scl_oe;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.oe_q = scl_oe;
    if (rel_now) begin
      nxt_st.hold_cnt = stretch_cyc;
    end else if (st_ff.hold_cnt != 8'h00) begin
      nxt_st.hold_cnt = st_ff.hold_cnt - 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ==========================================
  // Pull-up: a wire that nobody pulls reads high, never a stale level
  assign scl_line = !((scl_oe && !scl_out) || (st_ff.hold_cnt != 8'h00) ||
    (rel_now && (stretch_cyc != 8'h00)));
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
  import i2c_tim_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [31:0] ST_IDLE = 32'h0000_0014;
  localparam logic [31:0] ST_HOLD = 32'h0000_0094;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, scl_in, scl_out, scl_oe;
  logic run_req = 1'b0;
  logic fast_mode = 1'b0;
  logic [9:0] ev = '0;
  logic rx_nack = 1'b1;
  logic [1:0] bus_state = 2'h1;
  logic [7:0] rx_data = 8'hA5;
  logic [7:0] stretch_cyc = 8'h00;
  logic resume_go, ack_go, ack_nack, cmd_go, addr_go, data_go;
  logic [1:0] cmd_code;
  logic [7:0] addr_value, data_value;
  logic [31:0] rd;
  logic oe_q = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_resume = 0;
  int n_ack = 0;
  int n_cmd = 0;
  int n_addr = 0;
  int n_data = 0;
  int base;
  int run_len = 0;
  int low_run = 0;
  int high_run = 0;
  logic [31:0] tcfg [5] = '{32'h0000_0303, 32'h0000_0006, 32'h0900_0504, 32'h0307_0909,
    32'h0005_0000};
  logic tfast [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int tlow [5] = '{4, 7, 6, 4, 6};
  int thigh [5] = '{4, 7, 5, 8, 6};
  int stpos [6] = '{ST_LENGTH_ERROR, ST_CLIENTTO, ST_HOSTTO, ST_LOWTO, ST_ARB, ST_BUS_ERROR_FLAG};
  logic [7:0] regs [4] = '{IDX_SCL_TIMING, IDX_IRQ_EN_CLR, IDX_IRQ_EN_SET, IDX_IRQ_FLAGS};

  always #12.5 clk = ~clk;

  i2c_host_timing_irq u_i2c_host_timing_irq (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .run_req(run_req), .fast_mode(fast_mode), .byte_rx_done(ev[0]),
    .byte_tx_done(ev[1]), .nack_arb_lost(ev[2]), .start_unknown(ev[3]),
    .ev_length_error(ev[4]), .ev_client_stretch_timeout(ev[5]),
    .ev_host_stretch_timeout(ev[6]), .ev_scl_low_timeout(ev[7]),
    .ev_arbitration_lost(ev[8]), .ev_bus_error(ev[9]), .rx_nack(rx_nack),
    .bus_state(bus_state), .rx_data(rx_data), .resume_go(resume_go), .ack_go(ack_go),
    .ack_nack(ack_nack), .cmd_go(cmd_go), .cmd_code(cmd_code), .addr_go(addr_go),
    .addr_value(addr_value), .data_go(data_go), .data_value(data_value));
  scl_client_model u_scl_client_model (.clk(clk), .rst_b(rst_b), .scl_oe(scl_oe),
    .scl_out(scl_out), .stretch_cyc(stretch_cyc), .scl_line(scl_in));

  // ==========================================
  // Closing report
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // Monitor: pulse counts, SCL phase lengths, hang guard
  always @(posedge clk) begin
    cycles++;
    n_resume += int'(resume_go === 1'b1);
    n_addr += int'(addr_go === 1'b1);
    n_data += int'(data_go === 1'b1);
    n_ack += int'(ack_go === 1'b1);
    n_cmd += int'(cmd_go === 1'b1);
    if (scl_oe === oe_q) begin
      run_len++;
    end else begin
      if (oe_q) low_run = run_len;
      else high_run = run_len;
      run_len = 1;
    end
    oe_q = scl_oe;
    if (cycles > LIMIT) begin
      error_cnt++;
      test_done();
    end
  end

  // ==========================================
  // Bus access: hold the request until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // A wait that never ends is cut by the cycle limit of the monitor
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask
  task automatic rdx(input logic [7:0] idx);
    xfer(1'b0, idx, 32'h0);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ==========================================
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rdx(regs[i]);
      `CHK(rd, 32'h0)
    end
    rdx(IDX_BUS_STATUS);
    `CHK(rd, ST_IDLE)
    `CHK(irq, 1'b0)
    wr(8'h30, 32'hFFFF_FFFF);
    rdx(8'h30);
    `CHK(rd, 32'h0)
    wr(IDX_SCL_TIMING, 32'h1234_5678);
    rdx(IDX_SCL_TIMING);
    `CHK(rd, 32'h1234_5678)
    wr(IDX_IRQ_EN_SET, 32'hFF);
    rdx(IDX_IRQ_EN_SET);
    `CHK(rd, 32'h83)
    rdx(IDX_IRQ_EN_CLR);
    `CHK(rd, 32'h83)
    wr(IDX_IRQ_EN_CLR, 32'h01);
    rdx(IDX_IRQ_EN_SET);
    `CHK(rd, 32'h82)
    wr(IDX_IRQ_EN_CLR, 32'h00);
    wr(IDX_IRQ_EN_SET, 32'h00);
    rdx(IDX_IRQ_EN_CLR);
    `CHK(rd, 32'h82)
    wr(IDX_IRQ_EN_SET, 32'h01);
    // Phase lengths; the first case gives a 200 ns SCL period
    for (int i = 0; i < 5; i++) begin
      run_req <= 1'b0;
      repeat (30) @(posedge clk);
      wr(IDX_SCL_TIMING, tcfg[i]);
      fast_mode <= tfast[i];
      run_req <= 1'b1;
      repeat (60) @(posedge clk);
      `CHK(low_run, tlow[i])
      `CHK(high_run, thigh[i])
    end
    run_req <= 1'b0;
    repeat (30) @(posedge clk);
    wr(IDX_SCL_TIMING, tcfg[0]);
    fast_mode <= 1'b0;
    stretch_cyc <= 8'd10;
    run_req <= 1'b1;
    repeat (80) @(posedge clk);
    `CHK(high_run >= 11, 1'b1)
    stretch_cyc <= 8'h00;
    // Client flag: stretch survives a flag clear, data write releases
    pulse(0);
    repeat (10) @(posedge clk);
    rdx(IDX_IRQ_FLAGS);
    `CHK(rd, 32'h02)
    `CHK(irq, 1'b1)
    rdx(IDX_BUS_STATUS);
    `CHK(rd, ST_HOLD)
    `CHK(scl_oe, 1'b1)
    `CHK(scl_out, 1'b0)
    wr(IDX_IRQ_FLAGS, 32'h00);
    rdx(IDX_IRQ_FLAGS);
    `CHK(rd, 32'h02)
    wr(IDX_IRQ_FLAGS, 32'h02);
    rdx(IDX_IRQ_FLAGS);
    `CHK(rd, 32'h00)
    `CHK(irq, 1'b0)
    rdx(IDX_BUS_STATUS);
    `CHK(rd, ST_HOLD)
    `CHK(scl_oe, 1'b1)
    wr(IDX_DATA, 32'h5A);
    `CHK(data_value, 8'h5A)
    // Pulse counts settle one edge after the pulse is sampled
    @(posedge clk);
    `CHK(n_resume, 1)
    `CHK(n_data, 1)
    rdx(IDX_BUS_STATUS);
    `CHK(rd, ST_IDLE)
    // Host flag: empty command keeps the hold, a real one releases
    pulse(1);
    rdx(IDX_IRQ_FLAGS);
    `CHK(rd, 32'h01)
    wr(IDX_CONTROL_B, 32'h0);
    rdx(IDX_BUS_STATUS);
    `CHK(rd, ST_HOLD)
    wr(IDX_CONTROL_B, 32'h0003_0000);
    `CHK(cmd_code, 2'h3)
    @(posedge clk);
    `CHK(n_cmd, 1)
    rdx(IDX_IRQ_FLAGS);
    `CHK(rd, 32'h00)
    for (int k = 2; k < 4; k++) begin
      pulse(k);
      rdx(IDX_IRQ_FLAGS);
      `CHK(rd, 32'h01)
      wr(IDX_ADDR, 32'h33);
      `CHK(addr_value, 8'h33)
      @(posedge clk);
      `CHK(n_addr, k - 1)
      rdx(IDX_IRQ_FLAGS);
      `CHK(rd, 32'h00)
    end
    // Data read releases only with smart mode on
    pulse(0);
    rdx(IDX_DATA);
    rdx(IDX_BUS_STATUS);
    `CHK(rd, ST_HOLD)
    wr(IDX_CONTROL_B, 32'h0004_0100);
    base = n_ack;
    rdx(IDX_DATA);
    `CHK(rd, 32'hA5)
    @(posedge clk);
    `CHK(n_ack - base, 1)
    `CHK(ack_nack, 1'b1)
    rdx(IDX_BUS_STATUS);
    `CHK(rd, ST_IDLE)
    wr(IDX_CONTROL_B, 32'h0);
    for (int k = 4; k < 10; k++) begin
      pulse(k);
      rdx(IDX_IRQ_FLAGS);
      `CHK(rd[FLAG_ERROR], 1'b1)
      `CHK(irq, 1'b1)
      rdx(IDX_BUS_STATUS);
      `CHK(rd[stpos[k-4]], 1'b1)
      wr(IDX_ADDR, 32'h0);
      wr(IDX_IRQ_FLAGS, 32'h83);
      rdx(IDX_IRQ_FLAGS);
      `CHK(rd, 32'h00)
    end
    // Lost arbitration: host flag set but no stretch
    pulse(8);
    pulse(1);
    rdx(IDX_IRQ_FLAGS);
    `CHK(rd[FLAG_HOST], 1'b1)
    rdx(IDX_BUS_STATUS);
    `CHK(rd[ST_CLKHOLD], 1'b0)
    wr(IDX_ADDR, 32'h0);
    wr(IDX_IRQ_FLAGS, 32'h83);
    run_req <= 1'b0;
    repeat (20) @(posedge clk);
    test_done();
  end
endmodule
